// File: hdl/burst_beat_counter.sv
// Four-beat burst counter with interleaved or linear wrapping order
`timescale 1ns/10ps
module burst_beat_counter
(
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   // Control
   input  wire logic               load_now,      // Seed from a load cycle
   input  wire logic               step_now,      // Advance one beat
   input  wire sram_ft_pkg::beat_t seed,          // Low address bits of the load
   input  wire logic               interleaved,   // 1 interleaved, 0 linear
   // Beat
   output      sram_ft_pkg::beat_t beat_now,      // Beat used at this edge
   output      sram_ft_pkg::beat_t beat_r         // Beat used at the last edge
);
   import sram_ft_pkg::*;

   beat_t start_r;                                // Beat taken at load
   beat_t start_nxt;
   beat_t step_r;                                 // Beats advanced since load
   beat_t step_nxt;

   // Next start and step, and the beat they give
   always_comb
   begin
      start_nxt = start_r;
      step_nxt  = step_r;
      if (load_now)
      begin
         // New burst starts at the loaded low bits
         start_nxt = seed;                                   // see RQ16
         step_nxt  = BEAT_RST;
      end
      else if (step_now)
      begin
         // Step wraps after four beats
         step_nxt = beat_t'(step_r + 2'h1);                  // see RQ10
      end
      beat_now = beat_of(start_nxt, step_nxt, interleaved); // see RQ12
   end

   // Register counter state
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         start_r <= BEAT_RST;
         step_r  <= BEAT_RST;
         beat_r  <= BEAT_RST;
      end
      else
      begin
         start_r <= start_nxt;
         step_r  <= step_nxt;
         beat_r  <= beat_now;
      end
   end

endmodule : burst_beat_counter

// File: hdl/flowthrough_late_write_sram.sv
// Flow-through burst memory with late write and no bus turnaround gap
//
// Contract
// RQ1 - Array of 1,048,576 words, 18 bits each
// RQ2 - Write data taken one edge after command
// RQ3 - Read data flows out one cycle later
// RQ4 - Reads and writes mix freely, back to back
// RQ5 - Controller drives read-not-write low to write
// RQ6 - Lane enables pick bytes; all low writes word
// RQ7 - Lane enables and write address registered together
// RQ8 - Output enable may stay low through writes
// RQ9 - Any deselecting chip select floats the outputs
// RQ10 - Advance ignores address, selects, read-not-write; steps
// RQ11 - Clock gate high holds everything as frozen
// RQ12 - Order select 1 interleaved, 0 linear wrap
// RQ13 - Read-not-write high on load starts read
// RQ14 - Chip selects sampled only on load cycles
// RQ15 - Snooze floats outputs, ignores inputs, keeps data
// RQ16 - Load takes 20-bit address; low bits seed
`timescale 1ns/10ps
module flowthrough_late_write_sram
#(
   parameter int STORE_ABITS = sram_ft_pkg::ADDR_W  // Address bits kept in storage
)
(
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,
   // Command inputs
   input  wire sram_ft_pkg::addr_t  address,               // Word address
   input  wire logic                chip_select_first_n,   // Select, active low
   input  wire logic                chip_select_second,    // Select, active high
   input  wire logic                chip_select_third_n,   // Select, active low
   input  wire logic                advance_or_load,       // 1 advance, 0 load
   input  wire logic                read_not_write,        // 1 read, 0 write
   input  wire logic                byte_lane_low_write_n, // Low lane write enable
   input  wire logic                byte_lane_high_write_n,// High lane write enable
   input  wire logic                clock_gate_n,          // 1 holds all operations
   // Static and mode inputs
   input  wire logic                burst_order_select,    // 1 interleaved, 0 linear
   input  wire logic                output_enable_n,       // Output enable, active low
   input  wire logic                snooze_request,        // 1 enters snooze
   // Data pins
   input  wire sram_ft_pkg::word_t  dq_in,                 // Data seen on the pins
   output      sram_ft_pkg::word_t  dq_out,                // Data driven on the pins
   output      logic                dq_oe_n                // Low while driving pins
);
   import sram_ft_pkg::*;

   // Storage, kept through snooze
   word_t    store_mem [2**STORE_ABITS];   // see RQ1

   // Control state
   op_t      op_r;                         // Burst kind of the current burst
   op_t      op_nxt;
   addr_t    addr_hi_r;                    // Address held for the burst
   addr_t    addr_hi_nxt;
   wr_pend_t pend_r;                       // Write waiting for its data
   wr_pend_t pend_nxt;
   word_t    dq_out_r;                     // Output data register
   word_t    dq_out_nxt;
   logic     dq_oe_n_r;                    // Output drive register
   logic     dq_oe_n_nxt;

   // Decoded command of this edge
   logic     edge_live;                    // Edge not gated and not in snooze
   logic     is_load;                      // Load cycle on a live edge
   logic     is_step;                      // Advance cycle on a live edge
   logic     selected;                     // All three selects active
   op_t      cur_op;                       // Operation carried out at this edge
   addr_t    cur_addr;                     // Word addressed at this edge
   beat_t    beat_now;                     // Beat used at this edge
   beat_t    beat_r;                       // Beat used at the last live edge
   lanes_t   lanes_n_in;                   // Lane enables as sampled

   // Write commit
   logic     commit;                       // Late data lands at this edge
   word_t    commit_word;                  // Word after merging the lanes
   word_t    read_word;                    // Word read, with late data forwarded

   // Command decode
   always_comb
   begin
      // Snooze and clock gate both freeze the edge
      edge_live  = !clock_gate_n && !snooze_request;                   // see RQ11
      is_load    = edge_live && !advance_or_load;
      is_step    = edge_live && advance_or_load;                       // see RQ10
      // Selects only matter on a load
      selected   = !chip_select_first_n && chip_select_second
                   && !chip_select_third_n;                            // see RQ14
      lanes_n_in = {byte_lane_high_write_n, byte_lane_low_write_n};
      if (is_load)
      begin
         if (!selected)
         begin
            cur_op = OP_IDLE;                                          // see RQ9
         end
         else if (read_not_write)
         begin
            cur_op = OP_READ;                                          // see RQ13
         end
         else
         begin
            cur_op = OP_WRITE;                                         // see RQ5
         end
         cur_addr = address;                                           // see RQ16
      end
      else
      begin
         // Bursts continue the loaded kind at the next beat
         cur_op   = is_step ? op_r : OP_IDLE;                          // see RQ10
         cur_addr = {addr_hi_r[ADDR_W-1:BEAT_W], beat_now};
      end
   end

   // Burst beat sequencing
   burst_beat_counter u_beat
   (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .load_now    (is_load),
      .step_now    (is_step),
      .seed        (address[BEAT_W-1:0]),
      .interleaved (burst_order_select),
      .beat_now    (beat_now),
      .beat_r      (beat_r)
   );

   // Late write data and read path
   always_comb
   begin
      commit      = edge_live && pend_r.valid;                         // see RQ2
      commit_word = merge_lanes(store_mem[pend_r.addr[STORE_ABITS-1:0]],
                                dq_in, pend_r.lanes_n);                // see RQ6
      read_word   = store_mem[cur_addr[STORE_ABITS-1:0]];
      // Forward a write landing now to a read of the same word
      if (commit && (pend_r.addr[STORE_ABITS-1:0] == cur_addr[STORE_ABITS-1:0]))
      begin
         read_word = commit_word;                                      // see RQ4
      end
   end

   // Storage write
   always_ff @(posedge clk_sys)
   begin
      if (commit)
      begin
         store_mem[pend_r.addr[STORE_ABITS-1:0]] <= commit_word;       // see RQ2
      end
   end

   // Next control and output values
   always_comb
   begin
      op_nxt      = op_r;
      addr_hi_nxt = addr_hi_r;
      pend_nxt    = pend_r;
      dq_out_nxt  = dq_out_r;
      dq_oe_n_nxt = dq_oe_n_r;
      if (snooze_request)
      begin
         // Pins float; pending write is abandoned
         dq_oe_n_nxt    = 1'b1;                                        // see RQ15
         pend_nxt.valid = 1'b0;
      end
      else if (edge_live)
      begin
         if (is_load)
         begin
            op_nxt      = cur_op;
            addr_hi_nxt = address;                                     // see RQ16
         end
         // Lanes and address registered with the command
         pend_nxt.valid   = (cur_op == OP_WRITE);                      // see RQ7
         pend_nxt.addr    = cur_addr;
         pend_nxt.lanes_n = lanes_n_in;
         unique case (cur_op)
            OP_READ:
            begin
               // Data flows out in the next cycle
               dq_out_nxt  = read_word;                                // see RQ3
               dq_oe_n_nxt = output_enable_n;
            end
            OP_WRITE:
            begin
               // No drive whatever the output enable does
               dq_oe_n_nxt = 1'b1;                                     // see RQ8
            end
            OP_IDLE:
            begin
               dq_oe_n_nxt = 1'b1;                                     // see RQ9
            end
            default:
            begin
               dq_oe_n_nxt = 1'b1;
            end
         endcase
      end
   end

   // Register control and outputs
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         op_r      <= OP_IDLE;
         addr_hi_r <= '0;
         pend_r    <= PEND_RST;
         dq_out_r  <= DATA_RST;
         dq_oe_n_r <= 1'b1;
      end
      else
      begin
         op_r      <= op_nxt;
         addr_hi_r <= addr_hi_nxt;
         pend_r    <= pend_nxt;
         dq_out_r  <= dq_out_nxt;
         dq_oe_n_r <= dq_oe_n_nxt;
      end
   end

   // Pins come straight from registers
   assign dq_out  = dq_out_r;
   assign dq_oe_n = dq_oe_n_r;

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // Selected read with output enable drives next cycle
   chk_read_drives: assert property (                                  // see RQ3
      (is_load && selected && read_not_write && !output_enable_n)
      |=> !dq_oe_n && (op_r == OP_READ))
      else $error("read load did not drive data next cycle");

   // Full-word write then read of same word returns the data
   chk_late_forward: assert property (                                 // see RQ4
      (is_load && selected && !read_not_write && lanes_n_in == 2'h0)
      ##1 (is_load && selected && read_not_write && !output_enable_n
           && address == $past(address))
      |=> (dq_out == $past(dq_in)) && !dq_oe_n)
      else $error("read after write missed the late data");

   // Write command registers lanes and address together
   chk_write_capture: assert property (                                // see RQ7
      (is_load && selected && !read_not_write)
      |=> pend_r.valid && pend_r.addr == $past(address)
          && pend_r.lanes_n == $past(lanes_n_in))
      else $error("write address or lanes not registered");

   // Writes never drive the pins
   chk_write_quiet: assert property (                                  // see RQ8
      (cur_op == OP_WRITE) |=> dq_oe_n)
      else $error("pins driven during write");

   // Any deselecting chip select floats the pins
   chk_deselect_float: assert property (                               // see RQ9
      (is_load && !selected) |=> dq_oe_n && (op_r == OP_IDLE))
      else $error("deselect left pins driven");

   // Advance keeps burst address and kind
   chk_advance_holds: assert property (                                // see RQ10
      is_step |=> $stable(addr_hi_r) && $stable(op_r))
      else $error("advance changed burst address or kind");

   // First advance after load gives order-correct beat
   chk_first_step: assert property (                                   // see RQ12
      is_load ##1 is_step
      |-> beat_now == ($past(burst_order_select) ? ($past(address[1:0]) ^ 2'h1)
                       : beat_t'($past(address[1:0]) + 2'h1)))
      else $error("burst order wrong on first advance");

   // Gated clock freezes burst kind, pending write, beat and outputs
   chk_gate_hold: assert property (                                    // see RQ11
      (clock_gate_n && !snooze_request)
      |=> $stable(op_r) && $stable(pend_r) && $stable(beat_r)
          && $stable(dq_oe_n) && $stable(dq_out))
      else $error("state moved while clock gated");

   // Snooze floats pins and starts nothing
   chk_snooze_float: assert property (                                 // see RQ15
      snooze_request |=> dq_oe_n && !pend_r.valid && $stable(op_r))
      else $error("snooze left pins driven or state moving");

   // Full-word late data lands in the word of the pending write
   chk_store_commit: assert property (                                 // see RQ2
      (commit && pend_r.lanes_n == 2'h0)
      |=> store_mem[$past(pend_r.addr[STORE_ABITS-1:0])] == $past(dq_in))
      else $error("late write data not stored");

   // Selected load with read-not-write high starts a read burst
   chk_load_read: assert property (                                    // see RQ13
      (is_load && selected && read_not_write) |=> (op_r == OP_READ))
      else $error("read load did not start a read burst");

   // Advance of a read burst drives whatever the selects show
   chk_step_drives: assert property (                                  // see RQ14
      (is_step && op_r == OP_READ && !output_enable_n) |=> !dq_oe_n)
      else $error("read advance did not drive data");

   // Main scenarios
   cov_read_burst: cover property (
      is_load && selected && read_not_write ##1 is_step [*3]);
   cov_write_read: cover property (
      (cur_op == OP_WRITE) ##1 (cur_op == OP_READ));
   cov_gated_burst: cover property (
      is_step ##1 clock_gate_n ##1 is_step);
   cov_snooze: cover property (
      snooze_request ##1 !snooze_request);

endmodule : flowthrough_late_write_sram

// File: hdl/sram_ft_pkg.sv
// Shared widths, types, reset values and helpers of the flow-through late-write memory
package sram_ft_pkg;

   // Array shape
   localparam int ADDR_W  = 20;           // Word address width, 1,048,576 words
   localparam int WORD_W  = 18;           // Data word width
   localparam int LANE_W  = 9;            // Bits per byte lane
   localparam int LANES   = 2;            // Byte lanes per word
   localparam int BEAT_W  = 2;            // Burst counter width, four beats
   localparam int LANE_LO = 0;            // Low lane position
   localparam int LANE_HI = 1;            // High lane position

   // Basic carriers
   typedef logic [ADDR_W-1:0] addr_t;     // Word address
   typedef logic [WORD_W-1:0] word_t;     // Data word
   typedef logic [LANES-1:0]  lanes_t;    // Active-low lane write enables
   typedef logic [BEAT_W-1:0] beat_t;     // Burst beat

   // Burst kind held between load cycles
   typedef enum logic [1:0]
   {
      OP_IDLE  = 2'b00,
      OP_READ  = 2'b01,
      OP_WRITE = 2'b10
   } op_t;

   // Write waiting for its data one edge later
   typedef struct packed
   {
      logic   valid;                      // A write is waiting for data
      addr_t  addr;                       // Word it lands in
      lanes_t lanes_n;                    // Lanes to write, active low
   } wr_pend_t;

   // Reset values
   localparam word_t    DATA_RST = 18'h00000;
   localparam beat_t    BEAT_RST = 2'h0;
   localparam lanes_t   LANE_RST = 2'h3;
   localparam wr_pend_t PEND_RST = '{valid: 1'b0, addr: 20'h00000, lanes_n: 2'h3};

   // Replace the enabled lanes of a stored word with new data
   function automatic word_t merge_lanes(input word_t old_w, input word_t new_w,
                                         input lanes_t lanes_n);
      word_t res;
      res = old_w;
      for (int i = 0; i < LANES; i++)
      begin
         if (!lanes_n[i])
         begin
            res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
         end
      end
      return res;
   endfunction : merge_lanes

   // Beat address for a start beat and a step count
   function automatic beat_t beat_of(input beat_t start, input beat_t step,
                                     input logic interleaved);
      beat_t res;
      res = interleaved ? (start ^ step) : beat_t'(start + step);
      return res;
   endfunction : beat_of

endpackage : sram_ft_pkg

// File: verif/bus_ctrl_model.sv
// Bus controller side of the shared data lines: late write data and wire resolution
`timescale 1ns/10ps
module bus_ctrl_model
(
   // Clock
   input  wire logic               clk_sys,
   // Device side of the pins
   input  wire sram_ft_pkg::word_t dq_out,    // Device drive value
   input  wire logic               dq_oe_n,   // Low while device drives
   // Controller write data
   input  wire logic               wr_en,     // Controller drives write data
   input  wire sram_ft_pkg::word_t wr_data,   // Late write data
   // Resolved wire
   output      sram_ft_pkg::word_t dq_in      // Level seen on the pins
);
   import sram_ft_pkg::*;

   word_t float_r = 18'h2aaaa;                // Changing pattern on a floating bus

   // Floating lines show no stale value
   always @(posedge clk_sys)
   begin
      float_r <= ~float_r;
   end

   // Late write data one edge after the command, device drive otherwise
   always_comb
   begin
      if (wr_en && !dq_oe_n)
         dq_in = 'x;                          // Bus fight
      else if (wr_en)
         dq_in = wr_data;
      else if (!dq_oe_n)
         dq_in = dq_out;
      else
         dq_in = float_r;
   end
endmodule : bus_ctrl_model

// File: verif/flowthrough_late_write_sram_tb.sv
// Self-checking bench of the flow-through late-write memory
`timescale 1ns/10ps
module flowthrough_late_write_sram_tb;
   import sram_ft_pkg::*;

   // Device pins, all driven from time zero
   logic   clk_sys = 1'b0, sys_rst = 1'b1;
   addr_t  address = 20'h00000;
   logic   chip_select_first_n = 1'b1, chip_select_second = 1'b0, chip_select_third_n = 1'b1;
   logic   advance_or_load = 1'b0, read_not_write = 1'b1;
   logic   byte_lane_low_write_n = 1'b1, byte_lane_high_write_n = 1'b1;
   logic   clock_gate_n = 1'b0, burst_order_select = 1'b1;
   logic   output_enable_n = 1'b0, snooze_request = 1'b0;
   logic   wr_en = 1'b0, dq_oe_n;
   word_t  wr_data = 18'h00000, dq_in, dq_out;
   // Reference state
   word_t  rmem [addr_t];                     // Expected array contents
   op_t    k = OP_IDLE;                       // Burst kind
   addr_t  bas, pa;                           // Burst start, pending write word
   beat_t  stp;                               // Steps since load
   lanes_t pl;                                // Pending write lanes
   logic   drv_v = 1'b0, eoe = 1'b1, ord = 1'b1;
   word_t  drv_d, edq;
   int     fail_count = 0, checks_done = 0;

   // Clock of 8 ns
   always #4 clk_sys = ~clk_sys;

   flowthrough_late_write_sram flowthrough_late_write_sram_i (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .address(address), .chip_select_first_n(chip_select_first_n),
      .chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
      .advance_or_load(advance_or_load), .read_not_write(read_not_write),
      .byte_lane_low_write_n(byte_lane_low_write_n),
      .byte_lane_high_write_n(byte_lane_high_write_n), .clock_gate_n(clock_gate_n),
      .burst_order_select(burst_order_select), .output_enable_n(output_enable_n),
      .snooze_request(snooze_request), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

   bus_ctrl_model bus_ctrl_model_i (.clk_sys(clk_sys), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
      .wr_en(wr_en), .wr_data(wr_data), .dq_in(dq_in));

   // Expected beat for a start and a step
   function automatic beat_t exp_beat(input beat_t s, input beat_t n, input logic il);
      return il ? (s ^ n) : beat_t'(s + n);
   endfunction : exp_beat

   // Expected word after a lane write
   function automatic word_t exp_merge(input word_t o, input word_t d, input lanes_t ln);
      return {ln[1] ? o[17:9] : d[17:9], ln[0] ? o[8:0] : d[8:0]};
   endfunction : exp_merge

   // Compare and count
   task automatic check(input string nm, input word_t seen, input word_t exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // One clock edge of commands, reference update and output check
   task automatic step(input logic ld, input logic [2:0] cs, input logic rw, input addr_t a,
                       input lanes_t ln, input word_t d, input logic oe, input logic g,
                       input logic z);
      addr_t ba;
      logic  p_eoe;
      word_t p_edq;
      @(posedge clk_sys);
      // Outputs after this edge belong to the command of the previous call
      p_eoe = eoe;
      p_edq = edq;
      advance_or_load <= ld;
      {chip_select_first_n, chip_select_second, chip_select_third_n} <= cs;
      read_not_write <= rw;
      address <= a;
      {byte_lane_high_write_n, byte_lane_low_write_n} <= ln;
      output_enable_n <= oe;
      clock_gate_n <= g;
      snooze_request <= z;
      burst_order_select <= ord;
      wr_en <= drv_v;
      wr_data <= drv_d;
      if (z)
      begin
         drv_v = 1'b0;                        // Pending write dropped
         eoe = 1'b1;
      end
      else if (!g)
      begin
         if (drv_v)
            rmem[pa] = exp_merge(rmem[pa], drv_d, pl);
         drv_v = 1'b0;
         if (!ld)
         begin
            k = (cs != 3'b010) ? OP_IDLE : (rw ? OP_READ : OP_WRITE);
            bas = a;
            stp = 2'h0;
         end
         else
            stp = beat_t'(stp + 2'h1);
         ba = {bas[19:2], exp_beat(bas[1:0], stp, ord)};
         eoe = !(k == OP_READ && !oe);
         if (!eoe)
            edq = rmem[ba];
         if (k == OP_WRITE)
         begin
            drv_v = 1'b1;
            drv_d = d;
            pa = ba;
            pl = ln;
         end
      end
      @(negedge clk_sys);
      check("dq_oe_n", word_t'(dq_oe_n), word_t'(p_eoe));
      if (!p_eoe)
         check("dq_out", dq_out, p_edq);
   endtask : step

   // Closing verdict
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      final_report();
   end

   // Main sequence
   initial
   begin
      addr_t ua;
      void'($urandom(20));
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // Fill four groups with full-word bursts, lowest and highest words included
      for (int u = 0; u < 4; u++)
         for (int b = 0; b < 4; b++)
            step(b != 0, 3'b010, 1'b0, {(u == 3) ? 18'h3ffff : 18'(u), 2'h0}, 2'h0,
                 word_t'($urandom), 1'b0, 1'b0, 1'b0);
      // Write then read the same word at once for each lane pattern, then each select off
      for (int l = 0; l < 4; l++)
      begin
         step(1'b0, 3'b010, 1'b0, 20'h00001, 2'(l), word_t'($urandom), 1'b0, 1'b0, 1'b0);
         step(1'b0, 3'b010, 1'b1, 20'h00001, 2'h3, 18'h00000, 1'b0, 1'b0, 1'b0);
      end
      for (int i = 0; i < 3; i++)
         step(1'b0, 3'b010 ^ 3'(1 << i), 1'b1, 20'h00001, 2'h0, 18'h0, 1'b0, 1'b0,
              1'b0);
      $display("test directed done");
      // Random mixes in both burst orders
      for (int ph = 0; ph < 2; ph++)
      begin
         ord = (ph == 0);
         step(1'b0, 3'b110, 1'b1, 20'h00000, 2'h3, 18'h0, 1'b0, 1'b0, 1'b0);
         for (int i = 0; i < 1200; i++)
         begin
            ua = {($urandom % 4 == 3) ? 18'h3ffff : 18'($urandom % 3), 2'($urandom)};
            step(1'($urandom), ($urandom % 4 == 0) ? 3'($urandom) : 3'b010, 1'($urandom),
                 ua, 2'($urandom), word_t'($urandom), $urandom % 8 == 0,
                 $urandom % 10 == 0, $urandom % 20 == 0);
         end
         $display("test random order %0d done", ord);
      end
      // Closing deselect so the last command is compared as well
      step(1'b0, 3'b110, 1'b1, 20'h00000, 2'h3, 18'h0, 1'b0, 1'b0, 1'b0);
      final_report();
   end
endmodule : flowthrough_late_write_sram_tb
